/* File: rtl/adc_out_pkg.sv */
// constants and types for the parallel sample output block
package adc_out_pkg;

  // word layout
  localparam int SAMPLE_BITS     = 16;
  localparam int SAMPLE_WORD_MSB = 15;
  localparam int INPUT_BITS      = 18;
  localparam int DIFF_BITS       = 19;

  // input units: 0.64 V on each side is 0x4000, so the difference at full scale is 0x8000
  localparam logic signed [DIFF_BITS-1:0] FULL_SCALE_DIFF = 19'sh08000;
  localparam logic [SAMPLE_BITS-1:0]      CODE_POS_FULL   = 16'h7fff;
  localparam logic [SAMPLE_BITS-1:0]      CODE_NEG_FULL   = 16'h8000;

  // pipeline: pin flops on the sampling side, the rest is the delay line
  localparam int LATENCY_CYCLES = 7;
  localparam int FRONT_STAGES   = 2;
  localparam int LINE_DEPTH     = LATENCY_CYCLES - FRONT_STAGES;
  localparam int FIFO_DEPTH     = 4;

  // strobe delay after the falling sampling edge
  localparam real        STROBE_DELAY_NS  = 3.8;
  localparam real        CLOCK_MHZ        = 200.0;
  localparam int         STROBE_DELAY_RAW = $rtoi(STROBE_DELAY_NS * CLOCK_MHZ / 1000.0);
  localparam int         STROBE_DELAY_CYC = (STROBE_DELAY_RAW < 1) ? 1 : STROBE_DELAY_RAW;
  localparam logic [2:0] STROBE_WAIT_INIT = 3'(STROBE_DELAY_CYC);

  typedef struct packed {
    logic                   over;
    logic [SAMPLE_BITS-1:0] word;
  } sample_t;

  typedef enum logic [2:0] {
    STROBE_LOW  = 3'b001,
    STROBE_WAIT = 3'b010,
    STROBE_HIGH = 3'b100
  } strobe_phase_t;

endpackage

/* File: rtl/sample_link_if.sv */
// valid/ready word channel between the block's own modules
`timescale 1ns/1ps
`default_nettype none

interface sample_link_if #(parameter int WIDTH = 17);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

`default_nettype wire

/* File: rtl/sample_fifo.sv */
// dual-clock fifo with gray-coded pointers
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  // filling side
  input wire logic    fill_clock,
  input wire logic    fill_rst,
  sample_link_if.sink fill,
  // draining side
  input wire logic      drain_clock,
  input wire logic      drain_rst,
  sample_link_if.source drain
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wbin;
    logic [PW-1:0]               wgray;
    logic [PW-1:0]               rgray_meta;
    logic [PW-1:0]               rgray_sync;
  } fill_state_t;

  typedef struct packed {
    logic [PW-1:0] rbin;
    logic [PW-1:0] rgray;
    logic [PW-1:0] wgray_meta;
    logic [PW-1:0] wgray_sync;
  } drain_state_t;

  fill_state_t  fs;
  fill_state_t  next_fs;
  drain_state_t ds;
  drain_state_t next_ds;
  logic         full;
  logic         empty;

  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // full when the write pointer is one lap ahead of the read pointer
  assign full        = fs.wgray == {~fs.rgray_sync[PW-1:PW-2], fs.rgray_sync[PW-3:0]};
  assign empty       = ds.rgray == ds.wgray_sync;
  assign fill.ready  = ~full;
  assign drain.valid = ~empty;
  assign drain.data  = fs.mem[ds.rbin[AW-1:0]];

  always_comb begin
    next_fs            = fs;
    next_fs.rgray_meta = ds.rgray;
    next_fs.rgray_sync = fs.rgray_meta;
    if (fill.valid && !full) begin
      next_fs.mem[fs.wbin[AW-1:0]] = fill.data;
      next_fs.wbin                 = fs.wbin + PW'(1);
      next_fs.wgray                = to_gray(fs.wbin + PW'(1));
    end
    if (fill_rst) begin
      next_fs = '0;
    end
  end

  always_comb begin
    next_ds            = ds;
    next_ds.wgray_meta = fs.wgray;
    next_ds.wgray_sync = ds.wgray_meta;
    if (drain.ready && !empty) begin
      next_ds.rbin  = ds.rbin + PW'(1);
      next_ds.rgray = to_gray(ds.rbin + PW'(1));
    end
    if (drain_rst) begin
      next_ds = '0;
    end
  end

  always_ff @(posedge fill_clock) begin
    fs <= next_fs;
  end

  always_ff @(posedge drain_clock) begin
    ds <= next_ds;
  end

endmodule // sample_fifo

`default_nettype wire

/* File: rtl/adc_parallel_sample_output.sv */
// parallel sample output of the converter: sampling, coding, latency and strobe
//
// Summary of operation
// - one sample per rising sampling clock edge
// - word appears seven cycles later, valid at strobe
// - sixteen bit two's complement, bit 15 MSB
// - full scale codes 7fff/8000, midscale 0000/ffff
// - over-range flag high beyond either full scale
// - over-range flag travels with its word
// - strobe rises a delay after falling edge
`timescale 1ns/1ps
`default_nettype none

module adc_parallel_sample_output
  import adc_out_pkg::*;
(
  // system clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // sampling clock from the link
  input  wire logic                         sample_clock_pos,
  // digitised levels of the two analog inputs
  input  wire logic signed [INPUT_BITS-1:0] analog_input_pos,
  input  wire logic signed [INPUT_BITS-1:0] analog_input_neg,
  // parallel sample outputs
  output logic [SAMPLE_BITS-1:0]            sample_word_bits,
  output logic                              over_range_flag,
  output logic                              data_valid_strobe,
  // status
  output logic                              sample_overrun
);

  typedef struct packed {
    logic    valid;
    sample_t s;
  } line_entry_t;

  // sampling-clock side
  typedef struct packed {
    logic                         rst_meta;
    logic                         rst_sync;
    logic [1:0]                   have;
    logic signed [INPUT_BITS-1:0] hold_pos;
    logic signed [INPUT_BITS-1:0] hold_neg;
    logic signed [INPUT_BITS-1:0] in_pos;
    logic signed [INPUT_BITS-1:0] in_neg;
    logic                         overrun;
  } front_state_t;

  // system-clock side
  typedef struct packed {
    logic                          clk_meta;
    logic                          clk_sync;
    logic                          clk_prev;
    logic                          ovr_meta;
    logic                          ovr_sync;
    line_entry_t [LINE_DEPTH-1:0]  line;
    logic                          out_valid;
    sample_t                       out;
    strobe_phase_t                 phase;
    logic [2:0]                    wait_cnt;
    logic                          strobe;
  } back_state_t;

  front_state_t fs;
  front_state_t next_fs;
  back_state_t  bs;
  back_state_t  next_bs;
  logic         seen_rise;
  logic         seen_fall;

  sample_link_if #(.WIDTH($bits(sample_t))) fill_link ();
  sample_link_if #(.WIDTH($bits(sample_t))) drain_link ();

  // difference of the two inputs, saturated to the code range
  function automatic sample_t format_sample(
    input logic signed [INPUT_BITS-1:0] pos,
    input logic signed [INPUT_BITS-1:0] neg
  );
    logic signed [DIFF_BITS-1:0] diff;
    sample_t                     r;
    diff = $signed({pos[INPUT_BITS-1], pos}) - $signed({neg[INPUT_BITS-1], neg});
    if (diff > FULL_SCALE_DIFF) begin
      r.over = 1'b1;
      r.word = CODE_POS_FULL;
    end else if (diff < -FULL_SCALE_DIFF) begin
      r.over = 1'b1;
      r.word = CODE_NEG_FULL;
    end else if (diff == FULL_SCALE_DIFF) begin
      // exact positive full scale is one code past the top
      r.over = 1'b0;
      r.word = CODE_POS_FULL;
    end else begin
      r.over = 1'b0;
      r.word = diff[SAMPLE_BITS-1:0];
    end
    return r;
  endfunction

  // ---- sampling clock domain ----

  assign fill_link.valid = fs.have[1];
  // word and flag share one fifo entry, so they cannot slip apart
  assign fill_link.data  = format_sample(fs.in_pos, fs.in_neg);

  always_comb begin
    next_fs          = fs;
    next_fs.rst_meta = rst;
    next_fs.rst_sync = fs.rst_meta;
    // first flop is the hold stage, taken at the rising edge
    next_fs.hold_pos = analog_input_pos;
    next_fs.hold_neg = analog_input_neg;
    next_fs.in_pos   = fs.hold_pos;
    next_fs.in_neg   = fs.hold_neg;
    next_fs.have     = {fs.have[0], 1'b1};
    // a sample the fifo cannot take is lost; the sticky bit tells
    if (fill_link.valid && !fill_link.ready) begin
      next_fs.overrun = 1'b1;
    end
    if (fs.rst_sync) begin
      next_fs.have    = 2'h0;
      next_fs.overrun = 1'b0;
    end
  end

  always_ff @(posedge sample_clock_pos) begin
    fs <= next_fs;
  end

  // ---- crossing ----

  sample_fifo #(
    .WIDTH ($bits(sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .fill_clock  (sample_clock_pos),
    .fill_rst    (fs.rst_sync),
    .fill        (fill_link.sink),
    .drain_clock (clock),
    .drain_rst   (rst),
    .drain       (drain_link.source)
  );

  // ---- system clock domain ----

  assign seen_rise = bs.clk_sync & ~bs.clk_prev;
  assign seen_fall = bs.clk_prev & ~bs.clk_sync;

  // popping once per falling edge matches the one push per rising edge, so the fifo does not fill
  assign drain_link.ready = seen_fall;

  always_comb begin
    next_bs          = bs;
    next_bs.clk_meta = sample_clock_pos;
    next_bs.clk_sync = bs.clk_meta;
    next_bs.clk_prev = bs.clk_sync;
    next_bs.ovr_meta = fs.overrun;
    next_bs.ovr_sync = bs.ovr_meta;

    // each falling edge shifts one slot; an empty fifo gives a hole
    if (seen_fall) begin
      for (int i = LINE_DEPTH - 1; i > 0; i--) begin
        next_bs.line[i] = bs.line[i-1];
      end
      next_bs.line[0].valid = drain_link.valid;
      next_bs.line[0].s     = sample_t'(drain_link.data);
    end

    // words change only while the strobe is low
    if (seen_rise) begin
      next_bs.out_valid = bs.line[LINE_DEPTH-1].valid;
      if (bs.line[LINE_DEPTH-1].valid) begin
        next_bs.out = bs.line[LINE_DEPTH-1].s;
      end
    end

    unique case (bs.phase)
      STROBE_LOW: begin
        if (seen_fall && bs.out_valid) begin
          next_bs.phase    = STROBE_WAIT;
          next_bs.wait_cnt = STROBE_WAIT_INIT;
        end
      end
      STROBE_WAIT: begin
        if (seen_rise) begin
          next_bs.phase = STROBE_LOW;
        end else if (bs.wait_cnt <= 3'h1) begin
          next_bs.phase  = STROBE_HIGH;
          next_bs.strobe = 1'b1;
        end else begin
          next_bs.wait_cnt = bs.wait_cnt - 3'h1;
        end
      end
      STROBE_HIGH: begin
        if (seen_rise) begin
          next_bs.phase  = STROBE_LOW;
          next_bs.strobe = 1'b0;
        end
      end
      default: begin
        next_bs.phase  = STROBE_LOW;
        next_bs.strobe = 1'b0;
      end
    endcase

    if (rst) begin
      next_bs       = '0;
      next_bs.phase = STROBE_LOW;
    end
  end

  always_ff @(posedge clock) begin
    bs <= next_bs;
  end

  // outputs straight from flops
  assign sample_word_bits  = bs.out.word;
  assign over_range_flag   = bs.out.over;
  assign data_valid_strobe = bs.strobe;
  assign sample_overrun    = bs.ovr_sync;

endmodule // adc_parallel_sample_output

`default_nettype wire

/* File: verif/adc_out_asserts.sv */
// checker on the pins of the parallel sample output
`timescale 1ns/1ps
`default_nettype none
module adc_out_asserts
  import adc_out_pkg::*;
(
  // clock and reset
  input wire logic                   clock,
  input wire logic                   rst,
  // outputs watched
  input wire logic [SAMPLE_BITS-1:0] sample_word_bits,
  input wire logic                   over_range_flag,
  input wire logic                   data_valid_strobe,
  input wire logic                   sample_overrun
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_reset_quiet;
    $fell(rst) |-> sample_word_bits == 16'h0000 && !over_range_flag && !data_valid_strobe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not clear after reset");
  property p_fill_wait;
    $fell(rst) |=> !data_valid_strobe [*8];
  endproperty
  a_fill_wait: assert property (p_fill_wait) else $error("strobe before pipeline filled");
  property p_word_steady;
    data_valid_strobe |-> $stable(sample_word_bits);
  endproperty
  a_word_steady: assert property (p_word_steady) else $error("word moved while strobe high");
  property p_flag_steady;
    data_valid_strobe |-> $stable(over_range_flag);
  endproperty
  a_flag_steady: assert property (p_flag_steady) else $error("flag moved while strobe high");
  property p_flag_code;
    over_range_flag |-> sample_word_bits == CODE_POS_FULL || sample_word_bits == CODE_NEG_FULL;
  endproperty
  a_flag_code: assert property (p_flag_code) else $error("flag without full scale code");
  property p_strobe_gap;
    $rose(data_valid_strobe) |=> !$rose(data_valid_strobe) [*4];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("two strobes in one sample");
  property p_strobe_rate;
    $rose(data_valid_strobe) |=> ##[1:9] $rose(data_valid_strobe);
  endproperty
  a_strobe_rate: assert property (p_strobe_rate) else $error("strobe missed a sample");
  property p_no_loss;
    !sample_overrun;
  endproperty
  a_no_loss: assert property (p_no_loss) else $error("sample lost");
endmodule // adc_out_asserts
bind adc_parallel_sample_output adc_out_asserts chk_u (.clock, .rst, .sample_word_bits, .over_range_flag,
  .data_valid_strobe, .sample_overrun);
`default_nettype wire

/* File: verif/capture_model.sv */
// capture logic latching each sample on the strobe
`timescale 1ns/1ps
`default_nettype none
module capture_model
  import adc_out_pkg::*;
(
  // pins of the converter
  input  wire logic                   data_valid_strobe,
  input  wire logic [SAMPLE_BITS-1:0] sample_word_bits,
  input  wire logic                   over_range_flag,
  // latched sample
  output var  sample_t                held
);
  // one stage for both so word and flag never slip apart
  always_ff @(posedge data_valid_strobe) begin
    held <= '{over: over_range_flag, word: sample_word_bits};
  end
endmodule // capture_model
`default_nettype wire

/* File: verif/tb_adc_parallel_sample_output.sv */
// testbench: coding, latency, flag and reset of the sample output
`timescale 1ns/1ps
`default_nettype none
module tb_adc_parallel_sample_output
  import adc_out_pkg::*;
;
  logic                         clock = 0;
  logic                         rst = 1;
  logic                         sample_clock_pos = 0;
  logic signed [INPUT_BITS-1:0] analog_input_pos = '0;
  logic signed [INPUT_BITS-1:0] analog_input_neg = '0;
  logic [SAMPLE_BITS-1:0]       sample_word_bits;
  logic                         over_range_flag;
  logic                         data_valid_strobe;
  logic                         sample_overrun;
  sample_t                      held;
  sample_t                      exp_q [0:2047];
  int failures = 0, n_compared = 0, n_rise = 0, n_fall = 0, n_cap = 0;
  // full scale, just beyond, midscale and far beyond, back to back
  localparam logic signed [INPUT_BITS-1:0] TP [9] = '{18'sh04000, 18'sh04001, -18'sh04000, -18'sh04000,
    18'sh00001, 18'sh00000, 18'sh00000, 18'sh1ffff, 18'sh12345};
  localparam logic signed [INPUT_BITS-1:0] TN [9] = '{-18'sh04000, -18'sh04000, 18'sh04000, 18'sh04001,
    18'sh00000, 18'sh00000, 18'sh00001, -18'sh20000, 18'sh10000};
  always #2.5 clock = ~clock;
  initial #3.3 forever #16 sample_clock_pos = ~sample_clock_pos;
  adc_parallel_sample_output dut_u (.clock, .rst, .sample_clock_pos, .analog_input_pos, .analog_input_neg,
    .sample_word_bits, .over_range_flag, .data_valid_strobe, .sample_overrun);
  capture_model cap_u (.data_valid_strobe, .sample_word_bits, .over_range_flag, .held);
  function automatic sample_t code(input logic signed [INPUT_BITS-1:0] p, input logic signed [INPUT_BITS-1:0] n);
    logic signed [DIFF_BITS-1:0] d;
    d = DIFF_BITS'(p) - DIFF_BITS'(n);
    if (d > FULL_SCALE_DIFF) code = '{1'b1, CODE_POS_FULL};
    else if (d == FULL_SCALE_DIFF) code = '{1'b0, CODE_POS_FULL};
    else if (d < -FULL_SCALE_DIFF) code = '{1'b1, CODE_NEG_FULL};
    else code = '{1'b0, d[15:0]};
  endfunction
  task automatic chk(input string what, input logic [16:0] e, input logic [16:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // inputs move just after the falling edge, well clear of the sampling edge
  task automatic put(input logic signed [INPUT_BITS-1:0] p, input logic signed [INPUT_BITS-1:0] n);
    @(negedge sample_clock_pos);
    @(posedge clock);
    analog_input_pos <= p;
    analog_input_neg <= n;
  endtask
  always @(posedge sample_clock_pos) begin
    exp_q[n_rise % 2048] = code(analog_input_pos, analog_input_neg);
    n_rise++;
  end
  always @(negedge sample_clock_pos) n_fall++;
  // word of rising edge k is latched after falling edge k+7
  always @(posedge data_valid_strobe) begin
    automatic int idx = n_fall - 8;
    #1;
    n_cap++;
    chk("captured sample", 17'(exp_q[idx % 2048]), 17'(held));
  end
  task automatic test_coding();
    int c0;
    // samples taken while the front end leaves reset are dropped
    repeat (3) @(posedge sample_clock_pos);
    for (int i = 0; i < 9; i++) put(TP[i], TN[i]);
    put(18'sh00000, 18'sh00000);
    c0 = n_cap;
    repeat (10) @(negedge sample_clock_pos);
    chk("strobes during coding", 17'h0000a, 17'(n_cap - c0));
    chk("overrun flag", 17'h00000, 17'(sample_overrun));
    $display("test coding done");
  endtask
  task automatic test_reset();
    int c0;
    put(18'sh00abc, 18'sh00000);
    @(posedge clock);
    rst <= 1'b1;
    repeat (24) @(posedge clock);
    chk("outputs in reset", 17'h00000, {over_range_flag, sample_word_bits});
    chk("strobe in reset", 17'h00000, 17'(data_valid_strobe));
    rst <= 1'b0;
    repeat (3) @(posedge sample_clock_pos);
    c0 = n_cap;
    put(-18'sh00abc, 18'sh00000);
    put(18'sh00000, 18'sh00000);
    repeat (12) @(posedge sample_clock_pos);
    chk("strobes after reset", 17'h00001, 17'(n_cap > c0));
    $display("test reset done");
  endtask
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (24) @(posedge clock);
    rst <= 1'b0;
    test_coding();
    test_reset();
    end_sim();
  end
  initial begin
    #100us;
    failures++;
    end_sim();
  end
endmodule // tb_adc_parallel_sample_output
`default_nettype wire
